/* logic/adc_seq_regs.vh */
/*
  Register map, field positions, reset values and conversion timing
  of the converter sequencer.
  Assumes it is included by bare name into Verilog-2005 design files.
*/
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// ****************************************************************
// Register byte offsets (word aligned)
// ****************************************************************
`define OFS_CTRL       8'h00
`define OFS_OPTION     8'h04
`define OFS_STATUS     8'h08
`define OFS_RESULT     8'h20

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_FLAG      7
`define CTRL_EIGHT     6
`define CTRL_SCAN      5
`define CTRL_MULTI     4
`define CTRL_RESET     7'h00

// ****************************************************************
// Option and status register fields
// ****************************************************************
`define OPT_PWR        1
`define OPT_CLKSRC     0
`define STAT_BUSY      0
`define STAT_PWR       1

// ****************************************************************
// Conversion timing in conversion clock ticks, DAC start code, low-ref mux code and result pad
// ****************************************************************
`define SAMPLE_LAST    3'h5
`define BIT_LAST_SUB   2'h2
`define DAC_MSB        10'h200
`define LOW_REF_SEL    4'hD
`define RES_PAD        6'h00

`endif

/* logic/sync2.v */
/*
  Two-stage synchroniser for a bundle of asynchronous levels.
  Assumes a single clock domain and a clock enable for freezing.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sync2

/* logic/sar_core.v */
/*
  Successive-approximation engine: sample phase then ten trial bits
  of three ticks each, 36 ticks per conversion.
  Assumes a synchronised comparator level that is high while the held
  input is at or above the DAC output, and one tick per clock at most.
*/
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module sar_core (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       tick,
  input  wire       start,
  input  wire       abort,
  input  wire       again,
  input  wire       comp_above,
  output wire       finish,
  output wire [9:0] result,
  output wire [9:0] dac_code,
  output wire       sample,
  output wire       busy
);

  reg       busy_q;
  reg       samp_q;
  reg [2:0] cnt_q;
  reg [1:0] sub_q;
  reg [9:0] mask_q;
  reg [9:0] code_q;
  wire      step;

  // Trial bit kept when the input is not below the DAC
  assign step   = busy_q & tick;
  assign result = comp_above ? code_q : (code_q & ~mask_q);
  assign finish = step & ~samp_q & (sub_q == `BIT_LAST_SUB) & mask_q[0];
  assign dac_code = code_q;
  assign sample   = samp_q;
  assign busy     = busy_q;

  // Sample, then binary search from the MSB down
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      samp_q <= 1'b0;
      cnt_q  <= 3'h0;
      sub_q  <= 2'h0;
      mask_q <= 10'h000;
      code_q <= 10'h000;
    end else if (ce) begin
      if (abort) begin
        busy_q <= 1'b0;
        samp_q <= 1'b0;
        code_q <= 10'h000;
      end else if (start) begin
        busy_q <= 1'b1;
        samp_q <= 1'b1;
        cnt_q  <= 3'h0;
        code_q <= 10'h000;
      end else if (step) begin
        if (samp_q) begin
          if (cnt_q == `SAMPLE_LAST) begin
            samp_q <= 1'b0;
            mask_q <= `DAC_MSB;
            code_q <= `DAC_MSB;
            sub_q  <= 2'h0;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end else if (sub_q == `BIT_LAST_SUB) begin
          sub_q <= 2'h0;
          if (mask_q[0]) begin
            // Back-to-back restart keeps 36 ticks per conversion
            busy_q <= again;
            samp_q <= again;
            cnt_q  <= 3'h0;
            code_q <= 10'h000;
          end else begin
            mask_q <= mask_q >> 1;
            code_q <= result | (mask_q >> 1);
          end
        end else begin
          sub_q <= sub_q + 2'h1;
        end
      end
    end
  end

endmodule // sar_core

/* logic/adc_sequence_control.v */
/*
  Converter sequencer with AHB-Lite register slave: control, option,
  status and eight left-justified result registers.
  Assumes a single bus clock, a comparator and RC oscillator arriving
  asynchronously on pins, and an analog mux and DAC driven from here.
*/
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "adc_seq_regs.vh"

// Contract
// - One 10-bit SAR converter, sixteen-way input mux, eight result registers.
// - Bus-clocked, four conversions take exactly 144 bus clock cycles.
// - RC results land synchronously, at most one channel per bus clock.
// - Clearing power-up bit aborts conversion and removes converter power.
// - Clock-source bit chooses RC oscillator or bus clock for conversion.
// - Full scale gives FFC0, bottom gives 0000, overrange saturates silently.
// - Results left-justified, low six bits always read zero.
// - Input sampled first, then compared bit by bit against DAC.
// - Channel codes map pins, reserved to low ref, refs and test.
// - Group results go to fixed registers; single mode fills in sequence.
// - Single channel converted four or eight times; scan picks continuous.
// - Four-conversion single scan fills registers five to eight, then halts.
// - Four-conversion continuous wraps, fifth result overwrites register five.
// - Flag sets after first full pass; control write clears, aborts, restarts.
// - Clock-source clear selects bus clock, set selects RC oscillator.
// - Eight-conversion continuous: ninth result overwrites register one, wraps.
module adc_sequence_control (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        rc_osc_clk,
  input  wire        comp_above,
  output wire [3:0]  mux_select,
  output wire [9:0]  dac_code,
  output wire        sample_hold,
  output wire        converter_power
);

  // ****************************************************************
  // Register index decode
  // ****************************************************************
  localparam [3:0] RI_CTRL = 4'h0;
  localparam [3:0] RI_OPT  = 4'h1;
  localparam [3:0] RI_STAT = 4'h2;
  localparam [3:0] RI_NONE = 4'h7;

  // Results at 8..15, anything else unmapped
  function [3:0] reg_index;
    input [7:0] a;
    begin
      if (a == `OFS_CTRL)
        reg_index = RI_CTRL;
      else if (a == `OFS_OPTION)
        reg_index = RI_OPT;
      else if (a == `OFS_STATUS)
        reg_index = RI_STAT;
      else if ((a[7:5] == `OFS_RESULT >> 5) && (a[1:0] == 2'b00))
        reg_index = {1'b1, a[4:2]};
      else
        reg_index = RI_NONE;
    end
  endfunction

  // Map channel code to mux source, reserved inputs to low ref
  function [3:0] mux_source;
    input [3:0] ch;
    begin
      if (ch[3:2] == 2'b10)
        mux_source = `LOW_REF_SEL;
      else
        mux_source = ch;
    end
  endfunction

  // Channel converted at a position of the sequence
  function [3:0] chan_at;
    input       multi;
    input       eight;
    input [3:0] ch;
    input [2:0] pos;
    begin
      if (!multi)
        chan_at = ch;
      else if (eight)
        chan_at = {ch[3], pos};
      else
        chan_at = {ch[3:2], pos[1:0]};
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state_q;
  reg        eight_conversion_select_q;
  reg        scan_q;
  reg        multi_channel_select_q;
  reg [3:0]  chan_sel_q;
  reg        sequence_complete_flag_q;
  reg        converter_power_up_q;
  reg        conv_clock_source_select_q;
  reg [2:0]  count_q;
  reg        start_q;
  reg [3:0]  mux_q;
  reg [9:0]  result_q [0:7];
  reg        rc_prev_q;
  reg [7:0]  addr_q;
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg        ready_q;
  reg [31:0] rdata_q;
  reg [31:0] rd_word;
  integer    i;

  wire [1:0] async_s;
  wire       rc_s;
  wire       comp_s;
  wire       tick;
  wire       finish;
  wire [9:0] sar_result;
  wire       sar_busy;
  wire       take;
  wire [3:0] wr_idx;
  wire       wr_ctrl;
  wire       wr_opt;
  wire       pwr_off;
  wire       abort;
  wire       last;
  wire       again;
  wire [2:0] dest;
  wire [2:0] next_count;

  // ****************************************************************
  // Pin synchronisers and conversion clock select
  // ****************************************************************
  sync2 #(
    .W (2)
  ) u_sync (
    .clk      (hclk),
    .rst_n    (hresetn),
    .ce       (clk_en),
    .async_in ({rc_osc_clk, comp_above}),
    .sync_out (async_s)
  );

  assign rc_s   = async_s[1];
  assign comp_s = async_s[0];

  // RC edge becomes one bus-clock tick, so one step per clock at most
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rc_prev_q <= 1'b0;
    else if (clk_en)
      rc_prev_q <= rc_s;
  end

  // Clear selects bus clock, set selects the RC oscillator
  assign tick = conv_clock_source_select_q ? (rc_s & ~rc_prev_q)
                                           : 1'b1;

  // ****************************************************************
  // Conversion engine
  // ****************************************************************
  assign take    = hsel & hready & htrans[1];
  assign wr_idx  = reg_index(addr_q);
  assign wr_ctrl = wr_pend_q & (wr_idx == RI_CTRL);
  assign wr_opt  = wr_pend_q & (wr_idx == RI_OPT);
  assign pwr_off = wr_opt & ~hwdata[`OPT_PWR];
  assign abort   = wr_ctrl | pwr_off;

  assign last = eight_conversion_select_q ? (count_q == 3'h7)
                                          : (count_q[1:0] == 2'h3);
  assign again = (state_q == ST_RUN) & (scan_q | ~last);
  // Register slot depends only on conversion width and position
  assign dest = eight_conversion_select_q ? count_q
                                          : {1'b1, count_q[1:0]};
  assign next_count = last ? 3'h0 : (count_q + 3'h1);

  sar_core u_sar (
    .clk        (hclk),
    .rst_n      (hresetn),
    .ce         (clk_en),
    .tick       (tick),
    .start      (start_q),
    .abort      (abort),
    .again      (again),
    .comp_above (comp_s),
    .finish     (finish),
    .result     (sar_result),
    .dac_code   (dac_code),
    .sample     (sample_hold),
    .busy       (sar_busy)
  );

  // ****************************************************************
  // Sequencer and result store
  // ****************************************************************
  // A control write wins over a conversion finishing in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q                    <= ST_IDLE;
      eight_conversion_select_q  <= 1'b0;
      scan_q                     <= 1'b0;
      multi_channel_select_q     <= 1'b0;
      chan_sel_q                 <= 4'h0;
      sequence_complete_flag_q   <= 1'b0;
      converter_power_up_q       <= 1'b0;
      conv_clock_source_select_q <= 1'b0;
      count_q                    <= 3'h0;
      start_q                    <= 1'b0;
      mux_q                      <= 4'h0;
      for (i = 0; i < 8; i = i + 1)
        result_q[i] <= 10'h000;
    end else if (clk_en) begin
      start_q <= 1'b0;
      if (wr_opt) begin
        converter_power_up_q       <= hwdata[`OPT_PWR];
        conv_clock_source_select_q <= hwdata[`OPT_CLKSRC];
      end
      if (wr_ctrl) begin
        eight_conversion_select_q <= hwdata[`CTRL_EIGHT];
        scan_q                    <= hwdata[`CTRL_SCAN];
        multi_channel_select_q    <= hwdata[`CTRL_MULTI];
        chan_sel_q                <= hwdata[3:0];
        sequence_complete_flag_q  <= 1'b0;
        count_q                   <= 3'h0;
        mux_q <= mux_source(chan_at(hwdata[`CTRL_MULTI],
                 hwdata[`CTRL_EIGHT], hwdata[3:0], 3'h0));
        if (converter_power_up_q && !pwr_off) begin
          state_q <= ST_RUN;
          start_q <= 1'b1;
        end else begin
          state_q <= ST_IDLE;
        end
      end else if (pwr_off) begin
        state_q <= ST_IDLE;
      end else if (finish && state_q == ST_RUN) begin
        result_q[dest] <= sar_result;
        count_q        <= next_count;
        mux_q <= mux_source(chan_at(multi_channel_select_q,
                 eight_conversion_select_q, chan_sel_q, next_count));
        if (last) begin
          sequence_complete_flag_q <= 1'b1;
          if (!scan_q)
            state_q <= ST_IDLE;
        end
      end
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Read word assembled from the captured address
  always @* begin
    rd_word = 32'h0000_0000;
    case (reg_index(addr_q))
      RI_CTRL: begin
        rd_word[`CTRL_FLAG]  = sequence_complete_flag_q;
        rd_word[`CTRL_EIGHT] = eight_conversion_select_q;
        rd_word[`CTRL_SCAN]  = scan_q;
        rd_word[`CTRL_MULTI] = multi_channel_select_q;
        rd_word[3:0]         = chan_sel_q;
      end
      RI_OPT: begin
        rd_word[`OPT_PWR]    = converter_power_up_q;
        rd_word[`OPT_CLKSRC] = conv_clock_source_select_q;
      end
      RI_STAT: begin
        rd_word[`STAT_BUSY] = sar_busy;
        rd_word[`STAT_PWR]  = converter_power_up_q;
      end
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
        // Ten bits at the top of the half-word, low six zero
        rd_word[15:0] = {result_q[addr_q[4:2]], `RES_PAD};
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Writes complete with no wait, reads insert one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else if (clk_en) begin
      if (rd_pend_q) begin
        rdata_q   <= rd_word;
        ready_q   <= 1'b1;
        rd_pend_q <= 1'b0;
        wr_pend_q <= 1'b0;
      end else begin
        wr_pend_q <= take & hwrite;
        rd_pend_q <= take & ~hwrite;
        if (take) begin
          addr_q <= haddr[7:0];
          if (!hwrite)
            ready_q <= 1'b0;
        end
      end
    end
  end

  assign hrdata          = rdata_q;
  assign hreadyout       = ready_q;
  assign hresp           = 1'b0;
  assign mux_select      = mux_q;
  assign converter_power = converter_power_up_q;

endmodule // adc_sequence_control

/* testbench/analog_model.sv */
/*
  Far-side model of the converter: one level per mux source, a
  sample-and-hold and a comparator against the DAC code.
  Assumes the bench sets the levels, in converter code units.
*/
`timescale 1ns/1ps
module analog_model (
  input  wire       hclk,
  input  wire [3:0] mux_select,
  input  wire [9:0] dac_code,
  input  wire       sample_hold,
  output reg        comp_above
);
  integer lvl [0:15];
  integer held;

  initial held = 0;

  // ****************************************
  // Track the selected source while sampling
  // ****************************************
  always @(posedge hclk) begin
    if (sample_hold)
      held <= lvl[mux_select];
  end

  // Above full scale the compare stays high, so codes saturate
  always @* begin
    comp_above = held >= dac_code;
  end
endmodule // analog_model

/* testbench/adc_seq_chk.sv */
/*
  Checker for the converter sequencer: bus handshake and conversion
  timing seen at the top ports.
  Assumes hready is tied to hreadyout.
*/
`timescale 1ns/1ps
module adc_seq_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [3:0]  mux_select,
  input wire        sample_hold,
  input wire        converter_power
);
  reg opt_q;
  reg clksrc_q;
  reg pwr_q;

  // ****************************************
  // Follow writes to the option register
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q  <= 1'b0;
      clksrc_q <= 1'b0;
      pwr_q  <= 1'b0;
    end else if (hready) begin
      opt_q <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h04);
      if (opt_q) begin
        clksrc_q <= hwdata[0];
        pwr_q  <= hwdata[1];
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready
    |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hwrite && hready
    |=> hreadyout) else $error("write wait state");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout)
    |-> $stable(hrdata)) else $error("read data moved");
  a_mux_reserved: assert property (mux_select[3:2] != 2'b10)
    else $error("reserved code on mux");
  a_power_follow: assert property (opt_q && hready |=> ##[0:1]
    converter_power == pwr_q) else $error("power bit not followed");
  a_power_abort: assert property (!converter_power |=> !sample_hold)
    else $error("sampling while unpowered");
  a_sample_len: assert property ($rose(sample_hold) && !clksrc_q
    |=> sample_hold [*5] ##1 !sample_hold) else $error("sample length");
  a_rc_slow: assert property ($rose(sample_hold) && clksrc_q
    |=> sample_hold [*8]) else $error("RC sample too short");
  a_hold_mux: assert property (sample_hold && $past(sample_hold)
    |-> $stable(mux_select)) else $error("mux moved in sample");
endmodule // adc_seq_chk

bind adc_sequence_control adc_seq_chk i_adc_seq_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .mux_select(mux_select), .sample_hold(sample_hold),
  .converter_power(converter_power)
);

/* testbench/testbench.sv */
/*
  Self-checking bench of the converter sequencer over AHB-Lite.
  Assumes the analog model and the bound checker beside the design.
*/
`timescale 1ns/1ps
module testbench;
  reg         hclk, hresetn, hsel, hwrite, rc_osc_clk, sh_q, clk_en;
  reg  [31:0] haddr, hwdata, rd, seed;
  reg  [1:0]  htrans;
  reg  [15:0] exp_q [1:8];
  wire [31:0] hrdata;
  wire        hreadyout, hresp, comp_above, sample_hold, converter_power;
  wire [3:0]  mux_select;
  wire [9:0]  dac_code;
  integer     n_mismatch, samples_checked, cyc, nrise, i, m, c;
  integer     rise_t [0:7];

  adc_sequence_control i_adc_sequence_control (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rc_osc_clk(rc_osc_clk),
    .comp_above(comp_above), .mux_select(mux_select),
    .dac_code(dac_code), .sample_hold(sample_hold),
    .converter_power(converter_power));
  analog_model i_analog_model (.hclk(hclk), .mux_select(mux_select),
    .dac_code(dac_code), .sample_hold(sample_hold),
    .comp_above(comp_above));

  // Bus clock and a free-running RC oscillator near 1.5 MHz
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    rc_osc_clk = 1'b0;
    forever #333 rc_osc_clk = ~rc_osc_clk;
  end

  // Cycle count, sampling starts and the hang limit
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (sample_hold === 1'b1 && !sh_q) begin
      if (nrise < 8) rise_t[nrise] = cyc;
      nrise = nrise + 1;
    end
    sh_q = sample_hold;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end

  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction

  // Expected left-justified result of one source
  function [15:0] res(input [3:0] ch);
    integer v;
    begin
      v = i_analog_model.lvl[(ch[3:2] == 2'b10) ? 4'hD : ch];
      if (v > 10'h3FF) v = 10'h3FF;
      res = v << 6;
    end
  endfunction

  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One single transfer; read data lands in rd
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask

  task wait_flag;
    integer k;
    begin
      k = 0;
      rd = 32'h0;
      while (rd[7] !== 1'b1 && k < 2000) begin
        bus(1'b0, 8'h00, 32'h0);
        k = k + 1;
      end
    end
  endtask

  task wait_rise;
    integer n;
    begin
      n = nrise;
      while (nrise == n) @(posedge hclk);
    end
  endtask

  task chk_res(input integer base, input integer cnt);
    integer p;
    begin
      for (p = base; p < base + cnt; p = p + 1) begin
        bus(1'b0, 8'h1C + 4 * p, 32'h0);
        check(rd, {16'h0, exp_q[p]});
      end
    end
  endtask

  // One pass in any mode, then every result register
  task run_seq(input [7:0] ctl);
    integer p;
    begin
      for (p = 0; p < 16; p = p + 1) i_analog_model.lvl[p] = rnd() & 32'h7FF;
      // References: high at full scale, low at zero, half between
      i_analog_model.lvl[12] = 32'h3FF;
      i_analog_model.lvl[13] = 32'h0;
      i_analog_model.lvl[14] = 32'h200;
      bus(1'b1, 8'h00, {24'h0, ctl});
      wait_flag;
      check(rd, {24'h0, 1'b1, ctl[6:0]});
      for (p = 0; p < (ctl[6] ? 8 : 4); p = p + 1)
        exp_q[(ctl[6] ? 1 : 5) + p] = res(!ctl[4] ? ctl[3:0] : ctl[6] ?
          {ctl[3], p[2:0]} : {ctl[3:2], p[1:0]});
      chk_res(1, 8);
      $display("Pass in mode %h done", ctl);
    end
  endtask

  // Continuous scan: timing, wrap, restart and power-off abort
  task run_cont(input [7:0] ctl);
    integer p, base, cnt, n;
    begin
      cnt = ctl[6] ? 8 : 4;
      base = ctl[6] ? 1 : 5;
      bus(1'b1, 8'h00, {24'h0, ctl});
      nrise = 0;
      wait_flag;
      while (nrise < 5) @(posedge hclk);
      check(rise_t[4] - rise_t[0], 32'h90);
      i_analog_model.lvl[ctl[3:0]] = rnd() & 32'h3FF;
      n = nrise + cnt + 1;
      while (nrise < n) @(posedge hclk);
      for (p = base; p < base + cnt; p = p + 1) exp_q[p] = res(ctl[3:0]);
      chk_res(base, cnt);
      wait_rise;
      repeat (15) @(posedge hclk);
      bus(1'b1, 8'h00, {24'h0, ctl});
      bus(1'b0, 8'h00, 32'h0);
      check(rd, {24'h0, 1'b0, ctl[6:0]});
      bus(1'b0, 8'h08, 32'h0);
      check(rd, 32'h3);
      wait_rise;
      @(posedge hclk);
      i_analog_model.lvl[ctl[3:0]] = rnd() & 32'h3FF;
      repeat (14) @(posedge hclk);
      bus(1'b1, 8'h04, 32'h0);
      repeat (400) @(posedge hclk);
      bus(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      chk_res(base, cnt);
      bus(1'b1, 8'h04, 32'h2);
      repeat (1000) @(posedge hclk);
      $display("Continuous mode %h done", ctl);
    end
  endtask

  task print_verdict;
    begin
      $display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    clk_en = 1'b1;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    sh_q = 1'b0;
    seed = 32'hC0D7;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    nrise = 0;
    for (i = 1; i < 9; i = i + 1) exp_q[i] = 16'h0;
    for (i = 0; i < 16; i = i + 1) i_analog_model.lvl[i] = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h80, 32'hFFFFFFFF);
    for (i = 0; i < 16; i = i + 1) begin
      bus(1'b0, 8'h04 * i, 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b1, 8'h00, 32'h05);
    repeat (100) @(posedge hclk);
    check(nrise, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h05);
    // A write while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    bus(1'b1, 8'h00, 32'h0A);
    clk_en <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h05);
    $display("Reset and unpowered tests done");
    bus(1'b1, 8'h04, 32'h2);
    repeat (1000) @(posedge hclk);
    for (m = 0; m < 4; m = m + 1)
      for (c = 0; c < 16; c = c + 1)
        run_seq({1'b0, m[1], 1'b0, m[0], c[3:0]});
    run_cont(8'h2C);
    run_cont(8'h61);
    bus(1'b1, 8'h04, 32'h3);
    run_seq(8'h14);
    bus(1'b1, 8'h04, 32'h2);
    print_verdict;
  end
endmodule // testbench
